// File: design/valve_position_safety_monitor.sv
// Valve position safety monitor: relay supervision, fault lockout, lamps,
// status pair and a classic Wishbone slave for selectors and status.
// Assumes all inputs are already synchronous to ref_clk_in.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`include "valve_monitor_params.svh"
`timescale 1ns/1ps
`default_nettype none

module valve_position_safety_monitor #(
  parameter int unsigned REACT_BASE_CYC = `REACT_BASE_MS * `CLK_KHZ,
  parameter int unsigned REACT_STEP_CYC = `REACT_STEP_MS * `CLK_KHZ,
  parameter int unsigned RESET_MAX_CYC  = `RESET_MAX_MS * `CLK_KHZ,
  parameter int unsigned CONTACTOR_CYC  = `CONTACTOR_MS * `CLK_KHZ,
  parameter int unsigned DISCREP_CYC    = `DISCREP_MS * `CLK_KHZ,
  parameter int unsigned FLASH_ON_CYC   = `FLASH_ON_MS * `CLK_KHZ,
  parameter int unsigned FLASH_OFF_CYC  = `FLASH_OFF_MS * `CLK_KHZ,
  parameter int unsigned FLASH_GAP_CYC  = `FLASH_GAP_MS * `CLK_KHZ
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        wb_cyc_in,
  input  wire logic                        wb_stb_in,
  input  wire logic                        wb_we_in,
  input  wire valve_monitor_pkg::wb_adr_t  wb_adr_in,
  input  wire logic [3:0]                  wb_sel_in,
  input  wire valve_monitor_pkg::wb_data_t wb_dat_in,
  output var  valve_monitor_pkg::wb_data_t wb_dat_out,
  output logic                             wb_ack_out,
  input  wire logic                        start_in,
  input  wire logic                        feedback_a_in,
  input  wire logic                        feedback_b_in,
  input  wire logic                        valve_sensor_a_in,
  input  wire logic                        valve_sensor_b_in,
  input  wire logic                        reset_button_input_in,
  input  wire logic                        contactor_feedback_input_in,
  output logic                             output_relay_a_out,
  output logic                             output_relay_b_out,
  output logic                             status_a_out,
  output logic                             status_b_out,
  output logic                             valve_lamp_out,
  output logic                             health_lamp_out,
  output logic                             relay_lamp_out
);
  import valve_monitor_pkg::*;

  // ========================================================================
  // Helpers
  // Contact level to "valve at home", NO contacts are inverted
  function automatic logic at_home(input logic contact, input logic is_no);
    at_home = contact ^ is_no;
  endfunction

  // Saturating counter step
  function automatic logic [31:0] sat_inc(input logic [31:0] v);
    sat_inc = (v == 32'hFFFF_FFFF) ? v : v + 32'h0000_0001;
  endfunction

  // ========================================================================
  // Storage
  logic [7:0]  ctrl_reg;           // Reaction and mode selectors
  mon_state_e  state_reg;          // Supervision state
  mon_state_e  state_next;
  fault_e      fault_reg;          // Stored fault
  fault_e      fault_next;
  logic [31:0] tmr_reg;            // Reaction timer
  logic [31:0] tmr_next;
  logic [31:0] btn_cnt_reg;        // Reset button hold time
  logic [31:0] cfb_cnt_reg;        // Contactor mismatch time
  logic [31:0] dis_cnt_reg;        // Feedback channel disagreement time
  logic        start_d_reg;        // Start, one cycle late
  logic        btn_d_reg;          // Button, one cycle late
  logic        relay_reg;          // Both relays share one drive
  logic        relay_next;
  flash_e      fl_state_reg;       // Flash phase
  flash_e      fl_state_next;
  logic [31:0] fl_cnt_reg;         // Flash phase timer
  logic [31:0] fl_cnt_next;
  logic [2:0]  fl_left_reg;        // Pulses left in this sequence
  logic [2:0]  fl_left_next;
  logic        status_a_reg;
  logic        status_b_reg;
  logic        valve_lamp_reg;
  logic        health_lamp_reg;
  logic        ack_reg;
  wb_data_t    dat_reg;

  // ========================================================================
  // Selector decode
  wire [3:0] react_sel  = ctrl_reg[`CTRL_REACT_RANGE];
  wire [3:0] mode_sel   = ctrl_reg[`CTRL_MODE_RANGE];
  wire [3:0] wiring     = mode_sel % `WIRING_KINDS;
  wire       b_no       = (wiring == `WIRING_BOTH_NO);
  wire       a_no       = b_no | (wiring == `WIRING_A_NO);
  // Modes 9 and up and reaction codes past 9 are refused outright
  wire       config_bad = (mode_sel >= `MODE_INVALID) |
                          (react_sel > `SEL_MAX);
  wire       continuous = (mode_sel >= `MODE_CONT_MIN);
  wire       reinforce  = (mode_sel >= `MODE_REINF_MIN) &
                          ~config_bad;
  // Limit grows 0.11 s per selector step from 0.5 s
  wire [31:0] react_limit = 32'(REACT_BASE_CYC +
                                react_sel * REACT_STEP_CYC);

  // ========================================================================
  // Input decode
  wire sense_a    = at_home(valve_sensor_a_in, a_no);
  wire sense_b    = at_home(valve_sensor_b_in, b_no);
  wire valve_home = sense_a & sense_b;
  wire valve_end  = ~sense_a & ~sense_b;
  wire fb_closed  = feedback_a_in & feedback_b_in;
  wire start_rise = start_in & ~start_d_reg;
  // NC contactor contacts read closed while the relays are off
  wire cfb_mismatch = reinforce &
                      (contactor_feedback_input_in == relay_reg);
  wire cfb_timeout  = (cfb_cnt_reg >= CONTACTOR_CYC);
  wire dis_timeout  = (dis_cnt_reg >= DISCREP_CYC);
  wire react_over   = (tmr_reg >= react_limit);
  wire fault_any    = (fault_reg != FLT_NONE);
  wire internal     = (fault_reg == FLT_DISCREP) |
                      (fault_reg == FLT_CONFIG);
  // A short press released with every input at rest clears the lockout
  wire btn_release  = btn_d_reg & ~reset_button_input_in;
  wire reset_ok     = btn_release & (btn_cnt_reg < RESET_MAX_CYC) &
                      ~start_in & fb_closed & valve_home &
                      ~cfb_mismatch & ~config_bad;

  // ========================================================================
  // Supervision state machine
  always_comb begin
    state_next = state_reg;
    fault_next = fault_reg;
    unique case (state_reg)
      ST_IDLE: begin
        // Power-up and cycle start both wait for full rest
        if (fb_closed & ~start_in & valve_home) begin
          state_next = ST_READY;
        end
      end
      ST_READY: begin
        if (~fb_closed | ~valve_home) begin
          state_next = ST_IDLE;
        end else if (start_rise) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        // First activation: valve must reach its end position in time
        if (~fb_closed) begin
          state_next = ST_RETURN;
        end else if (~start_in) begin
          state_next = ST_LOCK;
          fault_next = FLT_SEQUENCE;
        end else if (valve_end) begin
          state_next = ST_HELD;
        end else if (react_over) begin
          state_next = ST_LOCK;
          fault_next = FLT_START;
        end
      end
      ST_HELD: begin
        if (~fb_closed) begin
          state_next = ST_RETURN;
        end else if (continuous & ~start_in) begin
          state_next = ST_RETURN;
        end else if (continuous & ~valve_end) begin
          state_next = ST_LOCK;
          fault_next = FLT_SEQUENCE;
        end
      end
      ST_RETURN: begin
        // Cycle end: valve must be back home in time
        if (valve_home) begin
          state_next = ST_IDLE;
        end else if (react_over) begin
          state_next = ST_LOCK;
          fault_next = FLT_RETURN;
        end
      end
      ST_LOCK: begin
        if (reset_ok) begin
          state_next = ST_IDLE;
          fault_next = FLT_NONE;
        end
      end
      default: begin
        // Corrupt code: fail safe
        state_next = ST_LOCK;
        fault_next = FLT_CONFIG;
      end
    endcase
    // Monitors outside the sequence override it
    if (state_reg != ST_LOCK) begin
      if (config_bad) begin
        state_next = ST_LOCK;
        fault_next = FLT_CONFIG;
      end else if (dis_timeout) begin
        state_next = ST_LOCK;
        fault_next = FLT_DISCREP;
      end else if (cfb_timeout) begin
        state_next = ST_LOCK;
        fault_next = FLT_CONTACTOR;
      end
    end
  end

  // Timer restarts on every state change
  assign tmr_next = (state_next != state_reg) ? 32'h0000_0000 : sat_inc(tmr_reg);
  // Single test lets relays follow start after the check; decided from
  // next state so drop-out takes one clock, far inside 28 ms
  assign relay_next = (state_next == ST_ACTIVE) |
                      ((state_next == ST_HELD) & start_in);

  // State, fault and timer
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
      fault_reg <= FLT_NONE;
      tmr_reg   <= 32'h0000_0000;
      relay_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      tmr_reg   <= tmr_next;
      relay_reg <= relay_next;
    end
  end

  // ========================================================================
  // Watch counters
  // Counters saturate so a stuck input cannot wrap back to healthy
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_d_reg <= 1'b0;
      btn_d_reg   <= 1'b0;
      btn_cnt_reg <= 32'h0000_0000;
      cfb_cnt_reg <= 32'h0000_0000;
      dis_cnt_reg <= 32'h0000_0000;
    end else begin
      start_d_reg <= start_in;
      btn_d_reg   <= reset_button_input_in;
      btn_cnt_reg <= reset_button_input_in ? sat_inc(btn_cnt_reg)
                                           : 32'h0000_0000;
      cfb_cnt_reg <= cfb_mismatch ? sat_inc(cfb_cnt_reg)
                                  : 32'h0000_0000;
      dis_cnt_reg <= (feedback_a_in ^ feedback_b_in) ? sat_inc(dis_cnt_reg)
                                                     : 32'h0000_0000;
    end
  end

  // ========================================================================
  // Fault flash sequence: code-many pulses, then a long gap
  always_comb begin
    fl_state_next = fl_state_reg;
    fl_cnt_next   = fl_cnt_reg + 32'h0000_0001;
    fl_left_next  = fl_left_reg;
    if (!fault_any) begin
      // Idle in gap so a new fault starts with a clean pause
      fl_state_next = FL_GAP;
      fl_cnt_next   = 32'h0000_0000;
    end else begin
      unique case (fl_state_reg)
        FL_ON: begin
          if (fl_cnt_reg >= FLASH_ON_CYC - 1) begin
            fl_state_next = FL_OFF;
            fl_cnt_next   = 32'h0000_0000;
          end
        end
        FL_OFF: begin
          if (fl_cnt_reg >= FLASH_OFF_CYC - 1) begin
            fl_cnt_next = 32'h0000_0000;
            if (fl_left_reg <= 3'h1) begin
              fl_state_next = FL_GAP;
            end else begin
              fl_state_next = FL_ON;
              fl_left_next  = fl_left_reg - 3'h1;
            end
          end
        end
        FL_GAP: begin
          if (fl_cnt_reg >= FLASH_GAP_CYC - 1) begin
            fl_state_next = FL_ON;
            fl_cnt_next   = 32'h0000_0000;
            fl_left_next  = fault_reg;
          end
        end
        default: begin
          fl_state_next = FL_GAP;
          fl_cnt_next   = 32'h0000_0000;
        end
      endcase
    end
  end

  wire flash_lit = (fl_state_reg == FL_ON);

  // Flash registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fl_state_reg <= FL_GAP;
      fl_cnt_reg   <= 32'h0000_0000;
      fl_left_reg  <= 3'h0;
    end else begin
      fl_state_reg <= fl_state_next;
      fl_cnt_reg   <= fl_cnt_next;
      fl_left_reg  <= fl_left_next;
    end
  end

  // ========================================================================
  // Status pair and lamps
  wire start_class  = (fault_reg == FLT_START) | (fault_reg == FLT_SEQUENCE);
  wire return_class = (fault_reg == FLT_RETURN);
  wire stat_a_next  = ~fault_any | start_class;
  wire stat_b_next  = ~fault_any | return_class;
  wire vlamp_next   = fault_any ? flash_lit : valve_home;
  wire hlamp_next   = internal ? flash_lit : 1'b1;

  // Indicator registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_a_reg    <= 1'b1;
      status_b_reg    <= 1'b1;
      valve_lamp_reg  <= 1'b0;
      health_lamp_reg <= 1'b1;
    end else begin
      status_a_reg    <= stat_a_next;
      status_b_reg    <= stat_b_next;
      valve_lamp_reg  <= vlamp_next;
      health_lamp_reg <= hlamp_next;
    end
  end

  assign output_relay_a_out = relay_reg;
  assign output_relay_b_out = relay_reg;
  assign relay_lamp_out     = relay_reg;
  assign status_a_out       = status_a_reg;
  assign status_b_out       = status_b_reg;
  assign valve_lamp_out     = valve_lamp_reg;
  assign health_lamp_out    = health_lamp_reg;

  // ========================================================================
  // Wishbone slave: one wait state, writes land on the acknowledge edge
  wire      wb_req    = wb_cyc_in & wb_stb_in;
  wire      wb_hit    = wb_req & ~ack_reg;
  wire      sel_ctrl  = (wb_adr_in == `CTRL_ADDR);
  wire      sel_stat  = (wb_adr_in == `STATUS_ADDR);
  wire      ctrl_wr   = wb_req & ack_reg & wb_we_in & sel_ctrl & wb_sel_in[0];
  wire [31:0] status_word = {11'h000, cfb_mismatch, fb_closed, valve_end,
                             valve_home, relay_reg, 5'h00, fault_reg,
                             2'h0, state_reg};
  // Unmapped addresses answer with zero
  wire [31:0] rd_mux = sel_ctrl ? {24'h00_0000, ctrl_reg} :
                       sel_stat ? status_word : 32'h0000_0000;

  // Bus registers
  always_ff @(posedge ref_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_reg  <= 1'b0;
      dat_reg  <= 32'h0000_0000;
      ctrl_reg <= `CTRL_RESET;
    end else begin
      ack_reg <= wb_hit;
      if (wb_hit) begin
        dat_reg <= rd_mux;
      end
      if (ctrl_wr) begin
        ctrl_reg <= wb_dat_in[7:0];
      end
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;

endmodule // valve_position_safety_monitor

`default_nettype wire

// File: design/valve_monitor_params.svh
// Constants for the valve position safety monitor: timings, selector codes,
// register offsets and field positions.
// Assumes a 20 MHz system clock; times are in ms, counts derived in the top.
`ifndef VALVE_MONITOR_PARAMS_SVH
`define VALVE_MONITOR_PARAMS_SVH

// ==========================================================================
// Timing
`define CLK_KHZ         20000
`define REACT_BASE_MS   500
`define REACT_STEP_MS   110
`define RESET_MAX_MS    3000
`define CONTACTOR_MS    100
`define DISCREP_MS      100
`define FLASH_ON_MS     500
`define FLASH_OFF_MS    50
`define FLASH_GAP_MS    2000

// ==========================================================================
// Selector codes
`define SEL_MAX         4'h9
`define MODE_INVALID    4'h9
`define MODE_CONT_MIN   4'h3
`define MODE_REINF_MIN  4'h6
`define WIRING_KINDS    4'h3
`define WIRING_A_NO     4'h1
`define WIRING_BOTH_NO  4'h2

// ==========================================================================
// Registers
`define CTRL_ADDR       4'h0
`define STATUS_ADDR     4'h4
`define CTRL_RESET      8'h00
`define CTRL_REACT_RANGE 3:0
`define CTRL_MODE_RANGE  7:4

`endif

// File: design/valve_monitor_pkg.sv
// Types shared by the valve position safety monitor.
// Assumes the params header is included by the design files.
package valve_monitor_pkg;
  typedef logic [3:0]  wb_adr_t;   // Word byte address
  typedef logic [31:0] wb_data_t;  // Bus data word
  // Supervision states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_READY  = 6'h02,
    ST_ACTIVE = 6'h04,
    ST_HELD   = 6'h08,
    ST_RETURN = 6'h10,
    ST_LOCK   = 6'h20
  } mon_state_e;
  // Stored fault; the value is also the flash pulse count
  typedef enum logic [2:0] {
    FLT_NONE      = 3'h0,
    FLT_START     = 3'h1,
    FLT_SEQUENCE  = 3'h2,
    FLT_RETURN    = 3'h3,
    FLT_CONTACTOR = 3'h4,
    FLT_DISCREP   = 3'h5,
    FLT_CONFIG    = 3'h6
  } fault_e;
  // Lamp flash phases, one-hot
  typedef enum logic [2:0] {
    FL_ON  = 3'h1,
    FL_OFF = 3'h2,
    FL_GAP = 3'h4
  } flash_e;
endpackage

// File: testbench/valve_monitor_checker.sv
// Checker for the valve monitor: relay, status and lamp relations.
// Bound to the top module; it sees the top module's ports only.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Port watcher
module valve_monitor_checker (
  input wire logic ref_clk_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic feedback_a_in,
  input wire logic feedback_b_in,
  input wire logic reset_button_input_in,
  input wire logic output_relay_a_out,
  input wire logic output_relay_b_out,
  input wire logic relay_lamp_out,
  input wire logic status_a_out,
  input wire logic status_b_out,
  input wire logic health_lamp_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  wire fault = !(status_a_out && status_b_out); // Any stored fault shown
  wire fb_ok = feedback_a_in && feedback_b_in;  // Feedback circuit closed

  property p_relay_pair;
    (output_relay_a_out == output_relay_b_out) && (relay_lamp_out == output_relay_a_out);
  endproperty
  a_relay_pair: assert property (p_relay_pair) else $error("Relays or lamp split");
  property p_start_edge;
    $rose(output_relay_a_out) |-> $past(start_in) && !$past(start_in, 2);
  endproperty
  a_start_edge: assert property (p_start_edge) else $error("Relays rose without edge");
  property p_start_clean;
    $rose(output_relay_a_out) |-> !fault && $past(fb_ok);
  endproperty
  a_start_clean: assert property (p_start_clean) else $error("Relays rose unready");
  // One cycle from sampled cause to drop, far inside the reaction limit
  property p_drop_start;
    output_relay_a_out && !start_in |=> !output_relay_a_out;
  endproperty
  a_drop_start: assert property (p_drop_start) else $error("Late drop on start");
  property p_drop_fb;
    output_relay_a_out && !fb_ok |=> !output_relay_a_out;
  endproperty
  a_drop_fb: assert property (p_drop_fb) else $error("Late drop on feedback");
  property p_fault_off;
    fault |-> !output_relay_a_out;
  endproperty
  a_fault_off: assert property (p_fault_off) else $error("Relays on with fault");
  property p_health;
    !health_lamp_out |-> fault;
  endproperty
  a_health: assert property (p_health) else $error("Health lamp off, no fault");
  // No button release lately, so the fault has to stay
  property p_fault_hold;
    fault && !$past(reset_button_input_in) && !$past(reset_button_input_in, 2) |=> fault;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("Fault cleared alone");
endmodule // valve_monitor_checker

bind valve_position_safety_monitor valve_monitor_checker valve_monitor_checker_i (
  .ref_clk_in, .resetn_in, .start_in, .feedback_a_in, .feedback_b_in,
  .reset_button_input_in, .output_relay_a_out, .output_relay_b_out,
  .relay_lamp_out, .status_a_out, .status_b_out, .health_lamp_out);
`default_nettype wire

// File: testbench/safety_ctrl_model.sv
// Safety controller and valve model facing the monitor.
// Sensors NC or NO per input; commands come from the bench on rising edges.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Controller and valve
module safety_ctrl_model (
  input  wire logic clk_in,       // System clock
  input  wire logic start_cmd_in, // Requested start level
  input  wire logic fb_cmd_in,    // Requested feedback closed
  input  wire logic stuck_in,     // Valve jammed where it stands
  input  wire logic fitted_in,    // Contactor contacts wired in
  input  wire logic [1:0] no_in,  // NO wiring of sensor a, b
  input  wire logic relay_in,     // Monitor relay state
  output logic      start_out,
  output logic      feedback_a_out,
  output logic      feedback_b_out,
  output logic      sensor_a_out,
  output logic      sensor_b_out,
  output logic      contactor_out
);
  logic [1:0] ctrl_reg = 2'h0;   // Start and feedback, one edge late
  logic [4:0] travel_reg = 5'h00; // Valve stroke, 20 steps
  logic       cont_reg = 1'b1;    // NC contactor contacts, one edge behind
  // Contactors follow the relays one edge late
  always_ff @(posedge clk_in) begin
    cont_reg <= !relay_in;
  end
  // Controller outputs change only after an edge
  always_ff @(posedge clk_in) begin
    ctrl_reg <= {start_cmd_in, fb_cmd_in};
  end
  // Valve moves while energised and free, returns when dropped
  always_ff @(posedge clk_in) begin
    if (relay_in && !stuck_in && travel_reg != 5'h14) begin
      travel_reg <= travel_reg + 5'h01;
    end else if (!relay_in && !stuck_in && travel_reg != 5'h00) begin
      travel_reg <= travel_reg - 5'h01;
    end
  end
  assign start_out = ctrl_reg[1];
  assign feedback_a_out = ctrl_reg[0];
  assign feedback_b_out = ctrl_reg[0];
  assign sensor_a_out = (travel_reg == 5'h00) ^ no_in[1]; // NC closed only at home
  assign sensor_b_out = (travel_reg < 5'h02) ^ no_in[0];  // Skewed, disagree one step from home
  assign contactor_out = fitted_in && cont_reg; // Input open when unwired
endmodule // safety_ctrl_model
`default_nettype wire

// File: testbench/tb_top.sv
// Testbench for the valve monitor: bus tasks, partner model, checks.
// Assumes shortened timing parameters; inputs change on rising edges.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench top
module tb_top;
  import valve_monitor_pkg::*;
  localparam int LIMIT = 3000; // Cycle ceiling for a hang
  logic     clk = 1'b0;  // 20 MHz clock
  logic     rstn = 1'b0; // Active-low reset
  logic     cyc = 1'b0;  // Bus request
  logic     we = 1'b0;   // Write direction
  wb_adr_t  adr = 4'h0;  // Bus address
  wb_data_t wdat = 32'h0;
  wb_data_t rdat;
  wb_data_t q;           // Last word read
  logic     ack;
  logic     start_cmd = 1'b1; // Start high at power-up on purpose
  logic     fb_cmd = 1'b1;
  logic     stuck = 1'b0;
  logic     btn = 1'b0;
  logic     stb = 1'b0;           // Bus strobe, raised with cyc
  logic [3:0] sel = 4'h0;         // Byte lanes
  logic     fitted = 1'b0;        // Contactor contacts wired in
  logic [1:0] wiring = 2'h0;      // NO wiring of sensor a, b
  logic     start, fb_a, fb_b, sen_a, sen_b, cont, rel_a, rel_b;
  logic     st_a, st_b, lamp_v, lamp_h, lamp_r;
  int       n_mismatch = 0;
  int       comparisons = 0;
  int       cycles = 0;
  always #25 clk = ~clk;

  valve_position_safety_monitor #(.REACT_BASE_CYC(50), .REACT_STEP_CYC(10),
    .RESET_MAX_CYC(30), .CONTACTOR_CYC(8), .DISCREP_CYC(8), .FLASH_ON_CYC(5),
    .FLASH_OFF_CYC(2), .FLASH_GAP_CYC(10)) valve_position_safety_monitor_i (
    .ref_clk_in(clk), .resetn_in(rstn), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .start_in(start), .feedback_a_in(fb_a),
    .feedback_b_in(fb_b), .valve_sensor_a_in(sen_a), .valve_sensor_b_in(sen_b),
    .reset_button_input_in(btn), .contactor_feedback_input_in(cont),
    .output_relay_a_out(rel_a), .output_relay_b_out(rel_b), .status_a_out(st_a),
    .status_b_out(st_b), .valve_lamp_out(lamp_v), .health_lamp_out(lamp_h),
    .relay_lamp_out(lamp_r));
  safety_ctrl_model safety_ctrl_model_i (.clk_in(clk), .start_cmd_in(start_cmd),
    .fb_cmd_in(fb_cmd), .stuck_in(stuck), .fitted_in(fitted), .no_in(wiring),
    .relay_in(rel_a), .start_out(start),
    .feedback_a_out(fb_a), .feedback_b_out(fb_b), .sensor_a_out(sen_a),
    .sensor_b_out(sen_b), .contactor_out(cont));

  task automatic report_and_stop();
    $display("Mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input wb_data_t got, input wb_data_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input wb_adr_t a, input wb_data_t d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= 4'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_rel(input logic v, input int max);
    int n;
    n = 0;
    while (rel_a !== v && n < max) begin
      @(posedge clk);
      n++;
    end
    check({31'h0, rel_a}, {31'h0, v});
  endtask
  task automatic press(input int n);
    btn <= 1'b1;
    tick(n);
    btn <= 1'b0;
    tick(6);
  endtask
  task automatic check_status(input logic a, input logic b);
    check({30'h0, st_a, st_b}, {30'h0, a, b});
  endtask

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ========================================================
  // Main sequence
  initial begin
    tick(4);
    rstn <= 1'b1;
    tick(10);
    check({31'h0, rel_a}, 32'h0);
    start_cmd <= 1'b0;
    bus(1'b1, 4'h0, 32'h30);
    bus(1'b0, 4'h0, 32'h0);
    check(q, 32'h30);
    bus(1'b0, 4'hC, 32'h0);
    check(q, 32'h0);
    // Continuous cycle with full valve travel
    tick(4);
    start_cmd <= 1'b1;
    wait_rel(1'b1, 6);
    tick(30);
    check({31'h0, lamp_v}, 32'h0);
    start_cmd <= 1'b0;
    wait_rel(1'b0, 4);
    tick(30);
    check({31'h0, lamp_v}, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    check(q & 32'h73F, 32'h2);
    // Jammed valve, limit 50 + 2 * 10 cycles
    bus(1'b1, 4'h0, 32'h32);
    stuck <= 1'b1;
    tick(4);
    start_cmd <= 1'b1;
    wait_rel(1'b1, 6);
    tick(60);
    check({31'h0, rel_a}, 32'h1);
    wait_rel(1'b0, 20);
    tick(2);
    check_status(1'b1, 1'b0);
    start_cmd <= 1'b0;
    stuck <= 1'b0;
    bus(1'b0, 4'h4, 32'h0);
    check(q & 32'h700, 32'h100);
    press(40);
    check_status(1'b1, 1'b0);
    press(5);
    check_status(1'b1, 1'b1);
    // Forbidden mode, then back to single test
    bus(1'b1, 4'h0, 32'h90);
    tick(4);
    check_status(1'b0, 1'b0);
    bus(1'b1, 4'h0, 32'h0);
    press(5);
    check_status(1'b1, 1'b1);
    tick(4);
    start_cmd <= 1'b1;
    wait_rel(1'b1, 6);
    tick(30);
    fb_cmd <= 1'b0;
    wait_rel(1'b0, 5);
    start_cmd <= 1'b0;
    tick(30);
    fb_cmd <= 1'b1;
    tick(10);
    check_status(1'b1, 1'b1);
    // Both NO sensors, contactors fitted late, then a jam at the end
    wiring <= 2'h3;
    bus(1'b1, 4'h0, 32'h80);
    tick(12);
    bus(1'b0, 4'h4, 32'h0);
    check(q & 32'h700, 32'h400);
    press(5);
    check_status(1'b0, 1'b0);
    fitted <= 1'b1;
    press(5);
    check_status(1'b1, 1'b1);
    tick(4);
    start_cmd <= 1'b1;
    wait_rel(1'b1, 6);
    tick(30);
    check({31'h0, rel_a}, 32'h1);
    stuck <= 1'b1;
    start_cmd <= 1'b0;
    wait_rel(1'b0, 4);
    tick(60);
    check_status(1'b0, 1'b1);
    stuck <= 1'b0;
    tick(30);
    press(5);
    check_status(1'b1, 1'b1);
    check({31'h0, lamp_h}, 32'h1);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
